/* File: core/pfm_cfg.svh */
// Purpose: shared constants of the predriver fault manager
// Assumes: 100 MHz reference clock
// Notes:   report bit positions and filter timing
`ifndef PFM_CFG_SVH
`define PFM_CFG_SVH

`define PFM_CLK_MHZ        100
`define PFM_SAT_FILTER_US  10
`define PFM_SAT_FILTER_CYC (`PFM_SAT_FILTER_US * `PFM_CLK_MHZ)
`define PFM_RPT_W          5
`define PFM_BIT_OC         0
`define PFM_BIT_OL         1
`define PFM_BIT_STB        2
`define PFM_BIT_STG        3
`define PFM_BIT_OV         4
`define PFM_RPT_CLEAR      5'h00

`endif

/* File: core/pfm_pkg.sv */
// Purpose: types of the predriver fault manager
// Assumes: nothing beyond the config header
// Notes:   protection state of one control cycle
package pfm_pkg;
    typedef enum logic [1:0] {
        PFM_PROT_NONE,
        PFM_PROT_OFF,
        PFM_PROT_CLAMP_ON
    } pfm_prot_t;
endpackage : pfm_pkg

/* File: core/pfm_sat_filter.sv */
// Purpose: persistence filter for one saturation comparator
// Assumes: comparator input already synchronous to the clock
// Notes:   fires once per persistence run, restarts when disarmed
`timescale 1ns/1ps
`include "pfm_cfg.svh"

module pfm_sat_filter
    import pfm_pkg::*;
#(
    parameter int FILTER_CYC = `PFM_SAT_FILTER_CYC
)
(
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_arm,
    input  wire logic i_cmp,
    output logic      o_detect
);
    localparam int CW = $clog2(FILTER_CYC + 1);

    initial
    begin
        if (FILTER_CYC < 1)
            $error("pfm_sat_filter: FILTER_CYC must be at least 1");
    end

    logic [CW-1:0] cnt_reg;

    // counter restarts whenever drive is off or comparator drops
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n || !i_arm || !i_cmp)
            cnt_reg <= '0;
        else if (cnt_reg != CW'(FILTER_CYC))
            cnt_reg <= cnt_reg + CW'(1);
    end

    // single pulse when the condition has lasted the full filter time
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            o_detect <= 1'b0;
        else
            o_detect <= i_arm && i_cmp && (cnt_reg == CW'(FILTER_CYC - 1));
    end
endmodule : pfm_sat_filter

/* File: core/pfm_fault_manager.sv */
// Purpose: fault detection, protection latching and fault report for a
//          high-side plus clamp predriver
// Assumes: all inputs synchronous to i_ref_clk; comparators already
//          threshold-selected by the analog front end from o_*_thr_high
// Notes:   report loads into the shift register only while select is high
//          filter length is a parameter; the default is 10 us at 100 MHz
//          protection and report are cleared by separate events
`timescale 1ns/1ps
`include "pfm_cfg.svh"

module pfm_fault_manager
    import pfm_pkg::*;
#(
    parameter int SAT_FILTER_CYC = `PFM_SAT_FILTER_CYC
)
(
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_drive_enable_in,
    input  wire logic                  i_cycle_control_in,
    input  wire logic                  i_spi_select_n,
    input  wire logic                  i_loop_state,
    input  wire logic                  i_hs_request,
    input  wire logic                  i_clamp_request,
    input  wire logic                  i_hs_sat_cmp,
    input  wire logic                  i_clamp_sat_cmp,
    input  wire logic                  i_overcurrent,
    input  wire logic                  i_overvoltage,
    input  wire logic                  i_ov_interrupt_enable,
    input  wire logic                  i_hs_sat_threshold_sel,
    input  wire logic                  i_clamp_sat_threshold_sel,
    output logic                       o_high_side_drive,
    output logic                       o_clamp_drive,
    output logic                       o_fault_flag_n,
    output logic                       o_hs_thr_high,
    output logic                       o_clamp_thr_high,
    output logic [`PFM_RPT_W-1:0]      o_fault_report,
    output logic [`PFM_RPT_W-1:0]      o_shift_load_data,
    output logic                       o_shift_load
);
    // a zero-length filter would fire on the first saturated edge
    initial
    begin
        if (SAT_FILTER_CYC < 1)
            $error("pfm_fault_manager: SAT_FILTER_CYC must be at least 1");
    end

    // registered history and decoded events; the detectors compare the
    // current input with the last sampled value, so an event is seen in
    // the same cycle the input changes
    logic           ena_d_reg;
    logic           ctl_d_reg;
    logic           sel_d_reg;
    logic           loop_d_reg;
    logic           toggled_reg;
    pfm_prot_t      prot_reg;
    logic [`PFM_RPT_W-1:0] rpt_reg;
    logic           prio_lock;
    logic           cycle_on;
    logic           cycle_start;
    logic           cycle_end;
    logic           sel_rise;
    logic           hs_on;
    logic           clamp_on;
    logic           hs_sat;
    logic           clamp_sat;
    logic           ov_act;
    logic           destructive;

    // edge history of the control and select inputs
    // select resets high so a release of reset never reads as a rising edge
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            ena_d_reg  <= 1'b0;
            ctl_d_reg  <= 1'b0;
            sel_d_reg  <= 1'b1;
            loop_d_reg <= 1'b0;
        end
        else
        begin
            ena_d_reg  <= i_drive_enable_in;
            ctl_d_reg  <= i_cycle_control_in;
            sel_d_reg  <= i_spi_select_n;
            loop_d_reg <= i_loop_state;
        end
    end

    // a cycle begins when either input rises while the other is high
    // cycle_end is one cycle wide; open-load evaluation keys on it
    // a drop and a new rise in the next cycle are two separate events
    assign cycle_on    = i_drive_enable_in && i_cycle_control_in;
    assign cycle_start = cycle_on && !(ena_d_reg && ctl_d_reg);
    assign cycle_end   = !cycle_on && ena_d_reg && ctl_d_reg;
    assign sel_rise    = i_spi_select_n && !sel_d_reg;

    // drives follow the loop request unless protection holds them
    assign hs_on    = o_high_side_drive;
    assign clamp_on = o_clamp_drive;

    // one filter per switch; arm drops as soon as the drive turns off, so a
    // switch that protection has opened cannot keep a stale count
    pfm_sat_filter #(
        .FILTER_CYC (SAT_FILTER_CYC)
    ) u_hs_filter (
        .i_ref_clk  (i_ref_clk),
        .i_rst_n    (i_rst_n),
        .i_arm      (cycle_on && hs_on),
        .i_cmp      (i_hs_sat_cmp),
        .o_detect   (hs_sat)
    );

    pfm_sat_filter #(
        .FILTER_CYC (SAT_FILTER_CYC)
    ) u_clamp_filter (
        .i_ref_clk  (i_ref_clk),
        .i_rst_n    (i_rst_n),
        .i_arm      (cycle_on && clamp_on),
        .i_cmp      (i_clamp_sat_cmp),
        .o_detect   (clamp_sat)
    );

    // overvoltage only interrupts when enabled
    assign ov_act      = i_overvoltage && i_ov_interrupt_enable;
    // destructive faults all end in the same off state; overcurrent also
    // acts outside a cycle, saturation only while its filter is armed
    assign destructive = hs_sat || clamp_sat || i_overcurrent;

    // threshold selects go straight to the analog comparators
    // registered so the front end sees a clean level after a config change
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_hs_thr_high    <= 1'b0;
            o_clamp_thr_high <= 1'b0;
        end
        else
        begin
            o_hs_thr_high    <= i_hs_sat_threshold_sel;
            o_clamp_thr_high <= i_clamp_sat_threshold_sel;
        end
    end

    // protection latch: a new cycle releases it, but a fault in that same
    // cycle wins so a persistent short is never missed
    // off beats clamp-on: a short with the clamp held on would keep
    // stressing the switch
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            prot_reg <= PFM_PROT_NONE;
        else if (destructive && (cycle_on || i_overcurrent))
            prot_reg <= PFM_PROT_OFF;
        else if (ov_act && cycle_on && prot_reg != PFM_PROT_OFF)
            prot_reg <= PFM_PROT_CLAMP_ON;
        else if (cycle_start)
            prot_reg <= PFM_PROT_NONE;
    end

    // drive outputs: low outside a cycle, overridden by protection
    // registered so every pin comes from a flip-flop; the cost is one
    // cycle of latency from loop request to pin
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_high_side_drive <= 1'b0;
            o_clamp_drive     <= 1'b0;
        end
        else if (destructive)
        begin
            o_high_side_drive <= 1'b0;
            o_clamp_drive     <= 1'b0;
        end
        else if (ov_act && cycle_on && prot_reg != PFM_PROT_OFF)
        begin
            o_high_side_drive <= 1'b0;
            o_clamp_drive     <= 1'b1;
        end
        else
        begin
            unique case (prot_reg)
                PFM_PROT_OFF:
                begin
                    // only the first edge of a new cycle may turn a switch on
                    o_high_side_drive <= cycle_start && i_hs_request;
                    o_clamp_drive     <= cycle_start && i_clamp_request
                                         && !i_hs_request;
                end
                PFM_PROT_CLAMP_ON:
                begin
                    o_high_side_drive <= cycle_start && i_hs_request;
                    o_clamp_drive     <= cycle_on && !(cycle_start && i_hs_request);
                end
                default:
                begin
                    // cross-conduction guard: high side wins the request
                    o_high_side_drive <= cycle_on && i_hs_request;
                    o_clamp_drive     <= cycle_on && i_clamp_request && !i_hs_request;
                end
            endcase
        end
    end

    // loop state change tracking across the control cycle
    // any change of the loop input while the cycle runs proves load current;
    // the mark restarts at each cycle start so one cycle never covers the next
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            toggled_reg <= 1'b0;
        else if (cycle_start)
            toggled_reg <= 1'b0;
        else if (cycle_on && (i_loop_state != loop_d_reg))
            toggled_reg <= 1'b1;
    end

    // lock means a priority bit already holds the report; overvoltage
    // counts as priority only while its interrupt is enabled
    assign prio_lock = rpt_reg[`PFM_BIT_OC] || rpt_reg[`PFM_BIT_STB]
                       || rpt_reg[`PFM_BIT_STG]
                       || (rpt_reg[`PFM_BIT_OV] && i_ov_interrupt_enable);

    // fault report: detection sets win over a same-cycle select clear
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            rpt_reg <= `PFM_RPT_CLEAR;
        else
        begin
            // r collects this cycle's changes before the single update
            logic [`PFM_RPT_W-1:0] r;
            r = sel_rise ? `PFM_RPT_CLEAR : rpt_reg;
            if (!prio_lock || sel_rise)
            begin
                // simultaneous detections: overcurrent takes the slot first
                if (i_overcurrent)
                    r[`PFM_BIT_OC] = 1'b1;
                else if (hs_sat)
                    r[`PFM_BIT_STG] = 1'b1;
                else if (clamp_sat)
                    r[`PFM_BIT_STB] = 1'b1;
                else if (ov_act && cycle_on)
                    r[`PFM_BIT_OV] = 1'b1;
            end
            if (i_overvoltage && !i_ov_interrupt_enable)
                r[`PFM_BIT_OV] = 1'b1;
            // open load is added last and only into an otherwise empty
            // report, so it can never hide or displace a priority fault
            if (cycle_end && !toggled_reg && r == `PFM_RPT_CLEAR)
                r[`PFM_BIT_OL] = 1'b1;
            rpt_reg <= r;
        end
    end
    // the report port is the register itself, no extra stage
    assign o_fault_report = rpt_reg;

    // flag: only priority faults pull it low; sets win over the clear
    // open load and disabled overvoltage never reach this flag
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            o_fault_flag_n <= 1'b1;
        else if (destructive || (ov_act && cycle_on))
            o_fault_flag_n <= 1'b0;
        else if (sel_rise)
            o_fault_flag_n <= 1'b1;
    end

    // transfer to the shift register only while deselected
    // faults arriving mid-transfer do not disturb the host's read; they are
    // picked up on the first cycle after select returns high
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_shift_load      <= 1'b0;
            o_shift_load_data <= `PFM_RPT_CLEAR;
        end
        else
        begin
            o_shift_load      <= i_spi_select_n;
            o_shift_load_data <= i_spi_select_n ? rpt_reg : o_shift_load_data;
        end
    end
endmodule : pfm_fault_manager

/* File: dv/pfm_fault_manager_props.sv */
// Purpose: port-level checks of the fault manager
// Assumes: one clock, synchronous active-low reset
// Notes:   saturation run counted in helper logic
`timescale 1ns/1ps
`include "pfm_cfg.svh"

module pfm_fault_manager_chk
    import pfm_pkg::*;
#(
    parameter int SAT_FILTER_CYC = `PFM_SAT_FILTER_CYC
)
(
    input wire logic                 i_ref_clk,
    input wire logic                 i_rst_n,
    input wire logic                 i_drive_enable_in,
    input wire logic                 i_cycle_control_in,
    input wire logic                 i_spi_select_n,
    input wire logic                 i_hs_sat_cmp,
    input wire logic                 i_clamp_sat_cmp,
    input wire logic                 i_overcurrent,
    input wire logic                 i_overvoltage,
    input wire logic                 i_ov_interrupt_enable,
    input wire logic                 i_hs_sat_threshold_sel,
    input wire logic                 i_clamp_sat_threshold_sel,
    input wire logic                 o_high_side_drive,
    input wire logic                 o_clamp_drive,
    input wire logic                 o_fault_flag_n,
    input wire logic                 o_hs_thr_high,
    input wire logic                 o_clamp_thr_high,
    input wire logic [`PFM_RPT_W-1:0] o_fault_report,
    input wire logic [`PFM_RPT_W-1:0] o_shift_load_data,
    input wire logic                 o_shift_load
);
    int unsigned sat_cnt_reg;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // length of the current monitored saturation; a glitch restarts it
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n || !(i_drive_enable_in && i_cycle_control_in
            && ((i_hs_sat_cmp && o_high_side_drive) || (i_clamp_sat_cmp && o_clamp_drive))))
            sat_cnt_reg <= 0;
        else
            sat_cnt_reg <= sat_cnt_reg + 1;
    end

    sequence s_all_off;
        !o_high_side_drive && !o_clamp_drive && !o_fault_flag_n;
    endsequence

    property p_thr;
        $past(i_rst_n) |-> o_hs_thr_high == $past(i_hs_sat_threshold_sel)
            && o_clamp_thr_high == $past(i_clamp_sat_threshold_sel);
    endproperty
    property p_oc;
        i_overcurrent |=> s_all_off;
    endproperty
    property p_sat;
        sat_cnt_reg == SAT_FILTER_CYC |-> ##[0:4] s_all_off;
    endproperty
    property p_flag;
        !o_fault_flag_n |-> (o_fault_report & 5'h1d) != 5'h00;
    endproperty
    property p_lock;
        (o_fault_report & 5'h0d) != 5'h00 && !$rose(i_spi_select_n)
            |=> $stable(o_fault_report & 5'h0d);
    endproperty
    property p_clear;
        $rose(i_spi_select_n) && !i_overcurrent && !i_overvoltage && !i_drive_enable_in
            |=> o_fault_report == 5'h00 && o_fault_flag_n;
    endproperty
    property p_load;
        i_spi_select_n |=> o_shift_load;
    endproperty
    property p_hold;
        !i_spi_select_n |=> $stable(o_shift_load_data) && !o_shift_load;
    endproperty
    property p_ldat;
        i_spi_select_n |=> o_shift_load_data == $past(o_fault_report);
    endproperty
    property p_ovd;
        i_overvoltage && !i_ov_interrupt_enable && o_fault_flag_n && !i_overcurrent
            && !i_hs_sat_cmp && !i_clamp_sat_cmp |=> o_fault_flag_n;
    endproperty
    property p_ove;
        i_overvoltage && i_ov_interrupt_enable && i_drive_enable_in && i_cycle_control_in
            && o_fault_flag_n && !i_overcurrent
            |=> !o_high_side_drive && o_clamp_drive && !o_fault_flag_n;
    endproperty

    a_thr: assert property (p_thr) else $error("threshold copy wrong");
    a_oc: assert property (p_oc) else $error("overcurrent not handled");
    a_sat: assert property (p_sat) else $error("saturation not latched");
    a_flag: assert property (p_flag) else $error("flag without priority fault");
    a_lock: assert property (p_lock) else $error("priority report changed");
    a_clear: assert property (p_clear) else $error("select rise did not clear");
    a_load: assert property (p_load) else $error("no load while deselected");
    a_hold: assert property (p_hold) else $error("load while selected");
    a_ldat: assert property (p_ldat) else $error("load data not the report");
    a_ovd: assert property (p_ovd) else $error("disabled ov moved the flag");
    a_ove: assert property (p_ove) else $error("enabled ov not handled");
endmodule : pfm_fault_manager_chk

bind pfm_fault_manager pfm_fault_manager_chk #(.SAT_FILTER_CYC(SAT_FILTER_CYC))
    i_pfm_fault_manager_chk (.i_ref_clk, .i_rst_n, .i_drive_enable_in, .i_cycle_control_in,
    .i_spi_select_n, .i_hs_sat_cmp, .i_clamp_sat_cmp, .i_overcurrent, .i_overvoltage,
    .i_ov_interrupt_enable, .i_hs_sat_threshold_sel, .i_clamp_sat_threshold_sel,
    .o_high_side_drive, .o_clamp_drive, .o_fault_flag_n, .o_hs_thr_high,
    .o_clamp_thr_high, .o_fault_report, .o_shift_load_data, .o_shift_load);

/* File: dv/pfm_mosfet_model.sv */
// Purpose: external high side and clamp switches with their load
// Assumes: a short shows as saturation of the switch that conducts
// Notes:   the loop toggles only while load current flows
`timescale 1ns/1ps

module pfm_mosfet_model
(
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_hs_drive,
    input  wire logic i_clamp_drive,
    input  wire logic i_short_gnd,
    input  wire logic i_short_bat,
    input  wire logic i_open_load,
    output logic      o_loop_state,
    output logic      o_hs_sat_cmp,
    output logic      o_clamp_sat_cmp
);
    logic [1:0] ramp_reg;

    // an off switch never reads as saturated
    assign o_hs_sat_cmp    = i_hs_drive && i_short_gnd;
    assign o_clamp_sat_cmp = i_clamp_drive && i_short_bat;

    // current ramps while the high side conducts; an open load never reaches the peak
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            ramp_reg     <= 2'h0;
            o_loop_state <= 1'b0;
        end
        else if (i_hs_drive && !i_open_load)
        begin
            ramp_reg <= ramp_reg + 2'h1;
            if (ramp_reg == 2'h3)
                o_loop_state <= !o_loop_state;
        end
    end
endmodule : pfm_mosfet_model

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for the fault manager
// Assumes: short saturation filter, switches modelled behaviourally
// Notes:   table rows run whole control cycles, hand tests follow
`timescale 1ns/1ps
`include "pfm_cfg.svh"

module tb_top;
    localparam int SAT_CYC = 8;
    typedef struct packed {
        logic ena, hreq, creq, ovie, oc, ov, sg, sb, ol, hsel, csel;
        logic [4:0] rpt;
        logic flag_n;
    } pfm_row_t;
    // fields: ena hreq creq ovie oc ov sg sb ol hsel csel report flag_n
    pfm_row_t rows [9] = '{'{1,1,0,0,0,0,0,0,0,0,0,5'h00,1}, '{1,1,0,0,0,0,0,0,1,1,0,5'h02,1},
        '{1,1,0,0,0,0,1,0,0,0,1,5'h08,0}, '{1,0,1,0,0,0,0,1,0,1,1,5'h04,0},
        '{1,1,0,0,1,0,0,0,0,0,0,5'h01,0}, '{0,0,0,0,1,0,0,0,0,0,0,5'h01,0},
        '{1,1,0,0,0,1,0,0,0,0,0,5'h10,1}, '{1,1,0,1,0,1,0,0,0,0,0,5'h10,0},
        '{1,1,0,0,0,1,1,0,1,0,0,5'h18,0}};
    logic ref_clk, rst_n = 1'b0, sel_n = 1'b1, ena = 1'b0, ctl = 1'b0, hreq = 1'b0;
    logic creq = 1'b0, oc = 1'b0, ov = 1'b0, ovie = 1'b0, hsel = 1'b0, csel = 1'b0;
    logic sg = 1'b0, sb = 1'b0, ol = 1'b0;
    wire logic loop, hs_cmp, cl_cmp, hs_drv, cl_drv, flag_n, hs_thr, cl_thr, shld;
    wire logic [4:0] rpt, ldat;
    int miscompares = 0;
    int num_checks = 0;

    pfm_fault_manager #(.SAT_FILTER_CYC(SAT_CYC)) i_pfm_fault_manager (.i_ref_clk(ref_clk),
        .i_rst_n(rst_n), .i_drive_enable_in(ena), .i_cycle_control_in(ctl),
        .i_spi_select_n(sel_n), .i_loop_state(loop), .i_hs_request(hreq),
        .i_clamp_request(creq), .i_hs_sat_cmp(hs_cmp), .i_clamp_sat_cmp(cl_cmp),
        .i_overcurrent(oc), .i_overvoltage(ov), .i_ov_interrupt_enable(ovie),
        .i_hs_sat_threshold_sel(hsel), .i_clamp_sat_threshold_sel(csel),
        .o_high_side_drive(hs_drv), .o_clamp_drive(cl_drv), .o_fault_flag_n(flag_n),
        .o_hs_thr_high(hs_thr), .o_clamp_thr_high(cl_thr), .o_fault_report(rpt),
        .o_shift_load_data(ldat), .o_shift_load(shld));
    pfm_mosfet_model i_pfm_mosfet_model (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
        .i_hs_drive(hs_drv), .i_clamp_drive(cl_drv), .i_short_gnd(sg), .i_short_bat(sb),
        .i_open_load(ol), .o_loop_state(loop), .o_hs_sat_cmp(hs_cmp), .o_clamp_sat_cmp(cl_cmp));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // select low then high; the rise is what clears the report
    task automatic select_pulse;
        @(posedge ref_clk);
        sel_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        sel_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : select_pulse

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // cut a hang short well past the expected run of some 420 cycles
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        miscompares++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("reset report", 5'h00, rpt);
        foreach (rows[k])
        begin
            @(posedge ref_clk);
            {ena, hreq, creq, ovie, sg, sb, ol, hsel, csel} <= {rows[k].ena, rows[k].hreq,
                rows[k].creq, rows[k].ovie, rows[k].sg, rows[k].sb, rows[k].ol,
                rows[k].hsel, rows[k].csel};
            ctl <= 1'b1;
            repeat (10) @(posedge ref_clk);
            {oc, ov} <= {rows[k].oc, rows[k].ov};
            repeat (20) @(posedge ref_clk);
            {ena, ctl, oc, ov, sg, sb} <= 6'h00;
            repeat (4) @(posedge ref_clk);
            #1;
            chk("report", rows[k].rpt, rpt);
            chk("flag", {4'h0, rows[k].flag_n}, {4'h0, flag_n});
            chk("thr", {3'h0, rows[k].hsel, rows[k].csel}, {3'h0, hs_thr, cl_thr});
            chk("load data", rows[k].rpt, ldat);
            select_pulse();
            chk("cleared", {5'h00}, rpt);
            chk("flag cleared", 5'h01, {4'h0, flag_n});
            $display("test row %0d done", k);
        end
        // two saturation glitches shorter than the filter must not trip
        @(posedge ref_clk);
        {ena, ctl, hreq, creq, ol} <= 5'h1c;
        repeat (4) @(posedge ref_clk);
        repeat (2)
        begin
            sg <= 1'b1;
            repeat (SAT_CYC - 2) @(posedge ref_clk);
            sg <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        #1;
        chk("glitch drive", 5'h01, {4'h0, hs_drv});
        chk("glitch report", 5'h00, rpt);
        sel_n <= 1'b0;
        sg <= 1'b1;
        repeat (SAT_CYC + 4) @(posedge ref_clk);
        oc <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("first wins", 5'h08, rpt);
        chk("frozen load", 5'h00, ldat);
        {ctl, oc, sg} <= 3'h0;
        repeat (2) @(posedge ref_clk);
        ctl <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("released drive", 5'h01, {4'h0, hs_drv});
        chk("report kept", 5'h08, rpt);
        $display("test saturation sequence done");
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("mid reset report", 5'h00, rpt);
        chk("mid reset flag", 5'h01, {4'h0, flag_n});
        chk("mid reset drives", 5'h00, {3'h0, hs_drv, cl_drv});
        {rst_n, sel_n, ena, ctl} <= 4'hc;
        repeat (2) @(posedge ref_clk);
        $display("test reset done");
        tally_and_finish();
    end
endmodule : tb_top
